// *** src/ros_pkg.sv ***
// shared constants for the regulator oscillator sequencer
package ros_pkg;
  localparam int unsigned CLK_HZ           = 200_000_000;
  localparam int unsigned BASE_HZ          = 2_000_000;
  localparam int unsigned BIN_STEP_HZ      = 40_000;
  localparam int unsigned SYNC_MAX_HZ      = 2_600_000;
  localparam int unsigned ENABLE_DELAY_MS  = 16;
  localparam int unsigned ENABLE_DELAY_CYC = ENABLE_DELAY_MS * (CLK_HZ / 1000);
  localparam int unsigned SYNC_REASSERT_NS = 1000;
  localparam int unsigned SYNC_REASSERT_CYC = SYNC_REASSERT_NS * (CLK_HZ / 1_000_000) / 1000;
  localparam int unsigned SYNC_MIN_CYC     = CLK_HZ / SYNC_MAX_HZ;
  localparam int unsigned DEFAULT_PERIOD   = CLK_HZ / BASE_HZ;
  localparam int unsigned SYNC_TIMEOUT_CYC = DEFAULT_PERIOD + SYNC_REASSERT_CYC;
  localparam int unsigned BIN_W            = 4;
  localparam int unsigned PER_W            = 9;
  localparam int unsigned DUTY_W           = 8;
  localparam logic [7:0]  DUTY_MAX_FRAC    = 8'hE6;
  localparam logic [1:0]  SKIP_MAX_NORMAL  = 2'h3;
  localparam logic [1:0]  SKIP_MAX_FOLD    = 2'h1;
  localparam logic [3:0]  BIN_RESET        = 4'h1;

  typedef enum logic [2:0] {
    ROS_OFF,
    ROS_DELAY,
    ROS_SS_PRIMARY,
    ROS_SS_SECONDARY,
    ROS_RUN,
    ROS_FAULT
  } ros_state_t;

  function automatic logic [PER_W-1:0] ros_bin_period(input logic [BIN_W-1:0] bin);
    int unsigned f;
    f = BASE_HZ + BIN_STEP_HZ * int'(bin);
    return PER_W'((CLK_HZ + f / 2) / f);
  endfunction
endpackage

// *** src/ros_sync2.sv ***
// two-flop synchroniser for asynchronous pins
`timescale 1ns/1ps
`default_nettype none
module ros_sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta;

  if (W < 1) begin : g_bad_width
    $error("synchroniser width must be at least one");
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta <= '0;
      dout <= '0;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule
`default_nettype wire

// *** src/ros_rail_pwm.sv ***
// per-rail switching permit with duty and frequency foldback
`timescale 1ns/1ps
`default_nettype none
module ros_rail_pwm (
  input  wire logic                     clk,
  input  wire logic                     resetn,
  input  wire logic                     cycle_start,
  input  wire logic [ros_pkg::PER_W-1:0] period,
  input  wire logic [7:0]               duty,
  input  wire logic                     permit,
  input  wire logic                     fold_half,
  output logic                          sw_on
);
  logic [ros_pkg::PER_W:0] cnt, next_cnt, on_len, next_on_len;
  logic [1:0]              skip_cnt, next_skip_cnt;
  logic                    phase, next_phase;
  logic                    next_sw_on;
  logic [ros_pkg::PER_W:0] rail_per;
  logic [ros_pkg::PER_W:0] scaled;
  logic [1:0]              skip_max;
  logic                    full_req;

  always_comb begin
    rail_per = fold_half ? {period, 1'b0} : {1'b0, period};
    // on-time tracks the period so duty stays constant
    scaled   = (ros_pkg::PER_W+1)'(({8'h00, rail_per} * {10'h000, duty}) >> 8);
    if (duty > ros_pkg::DUTY_MAX_FRAC) begin
      scaled = (ros_pkg::PER_W+1)'(({8'h00, rail_per} * {10'h000, ros_pkg::DUTY_MAX_FRAC}) >> 8);
    end
    full_req = duty > ros_pkg::DUTY_MAX_FRAC;
    skip_max = fold_half ? ros_pkg::SKIP_MAX_FOLD : ros_pkg::SKIP_MAX_NORMAL;
    next_cnt      = cnt + 1'b1;
    next_on_len   = on_len;
    next_skip_cnt = skip_cnt;
    next_phase    = phase;
    if (!permit) begin
      next_cnt      = '0;
      next_on_len   = '0;
      next_skip_cnt = '0;
      next_phase    = 1'b0;
    end else if (cycle_start) begin
      // half-rate rail starts only on every other oscillator cycle
      next_phase = fold_half ? ~phase : 1'b0;
      if (!fold_half || !phase) begin
        next_cnt = '0;
        if (full_req && skip_cnt < skip_max) begin
          next_on_len   = rail_per;
          next_skip_cnt = skip_cnt + 2'h1;
        end else begin
          next_on_len   = scaled;
          next_skip_cnt = '0;
        end
      end
    end
    next_sw_on = permit && (next_cnt < next_on_len);
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt      <= '0;
      on_len   <= '0;
      skip_cnt <= '0;
      phase    <= 1'b0;
      sw_on    <= 1'b0;
    end else begin
      cnt      <= next_cnt;
      on_len   <= next_on_len;
      skip_cnt <= next_skip_cnt;
      phase    <= next_phase;
      sw_on    <= next_sw_on;
    end
  end
endmodule
`default_nettype wire

// *** src/ros_sequencer.sv ***
// power-up sequencer and shared spread-spectrum oscillator
`timescale 1ns/1ps
`default_nettype none
module ros_sequencer #(
  parameter int unsigned ENABLE_DELAY_CYCLES = ros_pkg::ENABLE_DELAY_CYC
) (
  input  wire logic                      clk,
  input  wire logic                      resetn,
  input  wire logic                      enable_pin,
  input  wire logic                      low_supply_lockout,
  input  wire logic                      supply_above_40v,
  input  wire logic                      supply_below_34v,
  input  wire logic                      input_above_20v,
  input  wire logic                      input_below_18v,
  input  wire logic                      primary_ss_done,
  input  wire logic                      secondary_ss_done,
  input  wire logic                      external_sync_input,
  input  wire logic [7:0]                primary_duty,
  input  wire logic [7:0]                secondary_duty,
  output logic                           internal_rails_on,
  output logic                           output_discharge_pin,
  output logic                           soft_start_reset,
  output logic                           primary_ss_enable,
  output logic                           secondary_ss_enable,
  output logic                           high_supply_shutdown,
  output logic                           primary_freq_foldback,
  output logic                           sync_locked,
  output logic [ros_pkg::BIN_W-1:0]      freq_bin,
  output logic                           osc_cycle_start,
  output logic                           primary_buck_rail_switch,
  output logic                           secondary_boost_rail_switch
);
  // parameters the counters cannot serve
  if (ENABLE_DELAY_CYCLES < 1 || ENABLE_DELAY_CYCLES > 32'h7FFF_FFFF) begin : g_bad_delay
    $error("ENABLE_DELAY_CYCLES out of range");
  end
  if (ros_pkg::SYNC_TIMEOUT_CYC >= (1 << ros_pkg::PER_W)) begin : g_bad_timeout
    $error("sync timeout does not fit the oscillator counter");
  end
  if (ros_pkg::SYNC_MIN_CYC < 2 || ros_pkg::SYNC_MIN_CYC > ros_pkg::DEFAULT_PERIOD) begin : g_bad_sync
    $error("sync window outside the oscillator period");
  end
  if (ros_pkg::DEFAULT_PERIOD >= (1 << ros_pkg::PER_W)) begin : g_bad_period
    $error("default period does not fit the oscillator counter");
  end

  logic [8:0] pins_s;
  logic       en_s, low_supply_lockout_s, ov_hi_s, ov_lo_s, hv_hi_s, hv_lo_s, ss1_s, ss2_s, sync_s;

  ros_sync2 #(.W(9)) u_sync (
    .clk    (clk),
    .resetn (resetn),
    .din    ({external_sync_input,
              secondary_ss_done,
              primary_ss_done,
              input_below_18v,
              input_above_20v,
              supply_below_34v,
              supply_above_40v,
              low_supply_lockout,
              enable_pin}),
    .dout   (pins_s)
  );

  assign en_s    = pins_s[0];
  assign low_supply_lockout_s  = pins_s[1];
  assign ov_hi_s = pins_s[2];
  assign ov_lo_s = pins_s[3];
  assign hv_hi_s = pins_s[4];
  assign hv_lo_s = pins_s[5];
  assign ss1_s   = pins_s[6];
  assign ss2_s   = pins_s[7];
  assign sync_s  = pins_s[8];

  // supply and input hysteresis latches
  logic ov_lat, next_ov_lat, hv_lat, next_hv_lat;

  always_comb begin
    next_ov_lat = ov_lat;
    if (ov_hi_s) begin
      next_ov_lat = 1'b1;
    end else if (ov_lo_s) begin
      next_ov_lat = 1'b0;
    end
    next_hv_lat = hv_lat;
    if (hv_hi_s) begin
      next_hv_lat = 1'b1;
    end else if (hv_lo_s) begin
      next_hv_lat = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ov_lat <= 1'b0;
      hv_lat <= 1'b0;
    end else begin
      ov_lat <= next_ov_lat;
      hv_lat <= next_hv_lat;
    end
  end

  // power-up sequencing
  ros_pkg::ros_state_t state, next_state;
  logic [31:0]         dly_cnt, next_dly_cnt;
  logic                fault;

  always_comb begin
    fault        = low_supply_lockout_s || ov_lat;
    next_state   = state;
    next_dly_cnt = dly_cnt;
    case (state)
      ros_pkg::ROS_OFF: begin
        next_dly_cnt = '0;
        if (en_s) begin
          next_state = ros_pkg::ROS_DELAY;
        end
      end
      ros_pkg::ROS_DELAY: begin
        next_dly_cnt = dly_cnt + 32'h1;
        if (dly_cnt >= ENABLE_DELAY_CYCLES - 1) begin
          next_state = ros_pkg::ROS_SS_PRIMARY;
        end
      end
      ros_pkg::ROS_SS_PRIMARY: begin
        if (ss1_s) begin
          next_state = ros_pkg::ROS_SS_SECONDARY;
        end
      end
      ros_pkg::ROS_SS_SECONDARY: begin
        if (ss2_s) begin
          next_state = ros_pkg::ROS_RUN;
        end
      end
      ros_pkg::ROS_RUN: begin
        next_state = ros_pkg::ROS_RUN;
      end
      ros_pkg::ROS_FAULT: begin
        if (!fault) begin
          next_state = ros_pkg::ROS_SS_PRIMARY;
        end
      end
      default: begin
        next_state = ros_pkg::ROS_OFF;
      end
    endcase
    if (!en_s) begin
      next_state = ros_pkg::ROS_OFF;
    end else if (fault && state != ros_pkg::ROS_OFF && state != ros_pkg::ROS_DELAY) begin
      next_state = ros_pkg::ROS_FAULT;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state   <= ros_pkg::ROS_OFF;
      dly_cnt <= '0;
    end else begin
      state   <= next_state;
      dly_cnt <= next_dly_cnt;
    end
  end

  logic switching_ok, running;

  always_comb begin
    running      = state == ros_pkg::ROS_RUN;
    switching_ok = !fault && (state == ros_pkg::ROS_SS_PRIMARY ||
                   state == ros_pkg::ROS_SS_SECONDARY || running);
  end

  // shared oscillator with sync follow and bin stepping
  logic [ros_pkg::PER_W-1:0] osc_cnt, next_osc_cnt, cur_per, next_cur_per;
  logic [ros_pkg::BIN_W-1:0] lfsr, next_lfsr, next_freq_bin;
  logic                      sync_d, next_sync_locked, next_cycle_start;
  logic                      sync_edge, cyc_end;

  always_comb begin
    sync_edge        = sync_s && !sync_d && running;
    next_sync_locked = sync_locked;
    cyc_end          = 1'b0;
    if (!running) begin
      next_sync_locked = 1'b0;
      cyc_end          = osc_cnt >= cur_per - 1'b1;
    end else if (sync_edge && osc_cnt >= ros_pkg::PER_W'(ros_pkg::SYNC_MIN_CYC - 1)) begin
      next_sync_locked = 1'b1;
      cyc_end          = 1'b1;
    end else if (sync_locked) begin
      if (osc_cnt >= ros_pkg::PER_W'(ros_pkg::SYNC_TIMEOUT_CYC - 1)) begin
        next_sync_locked = 1'b0;
        cyc_end          = 1'b1;
      end
    end else begin
      cyc_end = osc_cnt >= cur_per - 1'b1;
    end
    next_osc_cnt     = cyc_end ? '0 : osc_cnt + 1'b1;
    next_cycle_start = cyc_end;
    // de Bruijn step: 15-state sequence plus the all-zero code
    next_lfsr     = lfsr;
    next_cur_per  = cur_per;
    next_freq_bin = freq_bin;
    if (cyc_end) begin
      next_lfsr = {lfsr[2:0], lfsr[3] ^ lfsr[2] ^ (lfsr[2:0] == 3'h0)};
      if (next_sync_locked) begin
        next_freq_bin = '0;
        next_cur_per  = ros_pkg::ros_bin_period('0);
      end else begin
        next_freq_bin = lfsr;
        next_cur_per  = ros_pkg::ros_bin_period(lfsr);
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      osc_cnt         <= '0;
      cur_per         <= ros_pkg::PER_W'(ros_pkg::DEFAULT_PERIOD);
      lfsr            <= ros_pkg::BIN_RESET;
      freq_bin        <= '0;
      sync_d          <= 1'b0;
      sync_locked     <= 1'b0;
      osc_cycle_start <= 1'b0;
    end else begin
      osc_cnt         <= next_osc_cnt;
      cur_per         <= next_cur_per;
      lfsr            <= next_lfsr;
      freq_bin        <= next_freq_bin;
      sync_d          <= sync_s;
      sync_locked     <= next_sync_locked;
      osc_cycle_start <= next_cycle_start;
    end
  end

  // sequencing outputs
  logic next_rails, next_dis, next_ssr, next_ss1, next_ss2;

  always_comb begin
    next_rails = state != ros_pkg::ROS_OFF;
    next_dis   = next_state == ros_pkg::ROS_DELAY;
    next_ssr   = next_state == ros_pkg::ROS_OFF || next_state == ros_pkg::ROS_DELAY ||
                 next_state == ros_pkg::ROS_FAULT;
    next_ss1   = !next_ssr;
    next_ss2   = next_state == ros_pkg::ROS_SS_SECONDARY ||
                 next_state == ros_pkg::ROS_RUN;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      internal_rails_on     <= 1'b0;
      output_discharge_pin  <= 1'b0;
      soft_start_reset      <= 1'b1;
      primary_ss_enable     <= 1'b0;
      secondary_ss_enable   <= 1'b0;
      high_supply_shutdown  <= 1'b0;
      primary_freq_foldback <= 1'b0;
    end else begin
      internal_rails_on     <= next_rails;
      output_discharge_pin  <= next_dis;
      soft_start_reset      <= next_ssr;
      primary_ss_enable     <= next_ss1;
      secondary_ss_enable   <= next_ss2;
      high_supply_shutdown  <= next_ov_lat;
      primary_freq_foldback <= next_hv_lat;
    end
  end

  // per-rail permits after the oscillator
  ros_rail_pwm u_primary (
    .clk         (clk),
    .resetn      (resetn),
    .cycle_start (osc_cycle_start),
    .period      (cur_per),
    .duty        (primary_duty),
    .permit      (switching_ok && primary_ss_enable),
    .fold_half   (hv_lat),
    .sw_on       (primary_buck_rail_switch)
  );

  ros_rail_pwm u_secondary (
    .clk         (clk),
    .resetn      (resetn),
    .cycle_start (osc_cycle_start),
    .period      (cur_per),
    .duty        (secondary_duty),
    .permit      (switching_ok && secondary_ss_enable),
    .fold_half   (1'b0),
    .sw_on       (secondary_boost_rail_switch)
  );
endmodule
`default_nettype wire

// *** verif/ros_partner.sv ***
// soft start ramp model for both rails
`timescale 1ns/1ps
`default_nettype none
module ros_partner #(
  parameter int SS_CYC = 20
) (
  input  wire logic clk,
  input  wire logic pri_en,
  input  wire logic sec_en,
  output var  logic pri_done,
  output var  logic sec_done
);
  int pc = 0;
  int sc = 0;
  initial pri_done = 1'b0;
  initial sec_done = 1'b0;
  // each ramp ends a fixed time after its own enable
  always @(posedge clk) begin
    pc <= pri_en ? pc + 1 : 0;
    sc <= sec_en ? sc + 1 : 0;
    pri_done <= pri_en && pc >= SS_CYC;
    sec_done <= sec_en && sc >= SS_CYC;
  end
endmodule
`default_nettype wire

// *** verif/ros_checker.sv ***
// port-level assertions for the sequencer
`timescale 1ns/1ps
`default_nettype none
module ros_checker (
  input  wire logic                     clk,
  input  wire logic                     resetn,
  input  wire logic                     internal_rails_on,
  input  wire logic                     output_discharge_pin,
  input  wire logic                     soft_start_reset,
  input  wire logic                     primary_ss_enable,
  input  wire logic                     secondary_ss_enable,
  input  wire logic                     high_supply_shutdown,
  input  wire logic                     sync_locked,
  input  wire logic [ros_pkg::BIN_W-1:0] freq_bin,
  input  wire logic                     osc_cycle_start,
  input  wire logic                     primary_buck_rail_switch,
  input  wire logic                     secondary_boost_rail_switch
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  logic [9:0] on_cnt;
  logic [9:0] next_on_cnt;
  logic       sw_any;
  assign sw_any = primary_buck_rail_switch || secondary_boost_rail_switch;
  // length of the present unbroken buck on-time
  always_comb begin
    next_on_cnt = 10'h000;
    if (primary_buck_rail_switch) begin
      next_on_cnt = (on_cnt == 10'h3FF) ? on_cnt : on_cnt + 10'h001;
    end
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      on_cnt <= 10'h000;
    end else begin
      on_cnt <= next_on_cnt;
    end
  end
  sequence s_boost_up;
    !secondary_ss_enable ##1 secondary_ss_enable;
  endsequence
  property p_ssr_hold;
    soft_start_reset [*2] |-> !primary_ss_enable && !sw_any;
  endproperty
  property p_ov_block;
    high_supply_shutdown [*2] |-> !sw_any;
  endproperty
  property p_shutdown;
    !internal_rails_on [*2] |-> !primary_ss_enable && !secondary_ss_enable && !sw_any;
  endproperty
  property p_discharge;
    output_discharge_pin |-> !primary_ss_enable && !secondary_ss_enable && !sw_any;
  endproperty
  property p_order;
    s_boost_up |-> primary_ss_enable && $past(primary_ss_enable, 2);
  endproperty
  property p_bin_edge;
    $past(resetn) && $changed(freq_bin) |-> osc_cycle_start || $past(osc_cycle_start);
  endproperty
  property p_lock_bin;
    sync_locked && $past(sync_locked) && $past(osc_cycle_start) |-> freq_bin == 4'h0;
  endproperty
  property p_lock_run;
    sync_locked |-> internal_rails_on && $past(secondary_ss_enable);
  endproperty
  property p_full_run;
    on_cnt <= 10'h190;
  endproperty
  a_ssr_hold: assert property (p_ssr_hold) else $error("switching under soft start reset");
  a_ov_block: assert property (p_ov_block) else $error("switching in overvoltage");
  a_shutdown: assert property (p_shutdown) else $error("activity in shutdown");
  a_discharge: assert property (p_discharge) else $error("switching with discharge");
  a_order: assert property (p_order) else $error("boost before buck ramp");
  a_bin_edge: assert property (p_bin_edge) else $error("bin changed mid cycle");
  a_lock_bin: assert property (p_lock_bin) else $error("spread while locked");
  a_lock_run: assert property (p_lock_run) else $error("sync followed outside run");
  a_full_run: assert property (p_full_run) else $error("too many skipped offs");
endmodule
bind ros_sequencer ros_checker u_chk (.clk(clk), .resetn(resetn),
  .internal_rails_on(internal_rails_on), .output_discharge_pin(output_discharge_pin),
  .soft_start_reset(soft_start_reset), .primary_ss_enable(primary_ss_enable),
  .secondary_ss_enable(secondary_ss_enable), .high_supply_shutdown(high_supply_shutdown),
  .sync_locked(sync_locked), .freq_bin(freq_bin), .osc_cycle_start(osc_cycle_start),
  .primary_buck_rail_switch(primary_buck_rail_switch),
  .secondary_boost_rail_switch(secondary_boost_rail_switch));
`default_nettype wire

// *** verif/ros_sequencer_tb.sv ***
// self-checking bench for the sequencer
`timescale 1ns/1ps
`default_nettype none
module regulator_oscillator_sequencer_tb;
  localparam int DLY = 50;
  logic       clk = 1'b0, resetn = 1'b0, en = 1'b0, uv = 1'b0, ov40 = 1'b0, ov34 = 1'b1;
  logic       hv20 = 1'b0, hv18 = 1'b1, sync = 1'b0, sync_on = 1'b0;
  logic [7:0] dp = 8'h80;
  logic       pd, sd, irs, dis, ssr, pse, sse, hss, fold, lck, cst, bsw, ssw;
  logic [3:0] fb;
  wire  [8:0] mon = {irs, cst, ssr, fold, hss, lck, sse, pse, dis};
  int         errors = 0, samples_checked = 0, sc = 0;
  initial forever #2.5 clk = ~clk;
  always @(posedge clk) begin
    sc <= (sc == 89) ? 0 : sc + 1;
    sync <= sync_on && sc < 45;
  end
  ros_partner pm (.clk(clk), .pri_en(pse), .sec_en(sse), .pri_done(pd), .sec_done(sd));
  ros_sequencer #(.ENABLE_DELAY_CYCLES(DLY)) dut (.clk(clk), .resetn(resetn),
    .enable_pin(en), .low_supply_lockout(uv), .supply_above_40v(ov40),
    .supply_below_34v(ov34), .input_above_20v(hv20), .input_below_18v(hv18),
    .primary_ss_done(pd), .secondary_ss_done(sd), .external_sync_input(sync),
    .primary_duty(dp), .secondary_duty(8'h80), .internal_rails_on(irs),
    .output_discharge_pin(dis), .soft_start_reset(ssr), .primary_ss_enable(pse),
    .secondary_ss_enable(sse), .high_supply_shutdown(hss), .primary_freq_foldback(fold),
    .sync_locked(lck), .freq_bin(fb), .osc_cycle_start(cst),
    .primary_buck_rail_switch(bsw), .secondary_boost_rail_switch(ssw));
  task automatic wrap_up();
    $display("compared %0d, mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wt(input int s, input logic v, input int lim, output int n);
    n = 0;
    while (mon[s] !== v) begin
      @(posedge clk);
      #1;
      n++;
      if (n > lim) begin
        errors++;
        wrap_up();
      end
    end
  endtask
  function automatic int per(input logic [3:0] b);
    return (10050 + b) / (100 + 2 * b);
  endfunction
  task automatic cyc(output logic [3:0] b, output int len, output int hi, output int hi2);
    int n;
    wt(7, 1'b1, 400, n);
    @(posedge clk);
    #1;
    b = fb;
    len = 1;
    hi = int'(bsw);
    hi2 = int'(ssw);
    while (cst !== 1'b1 && len < 400) begin
      @(posedge clk);
      #1;
      len++;
      hi += int'(bsw);
      hi2 += int'(ssw);
    end
  endtask
  task automatic t_start();
    int n;
    @(posedge clk) en <= 1'b1;
    #1;
    wt(0, 1'b1, 10, n);
    wt(0, 1'b0, DLY + 10, n);
    chk(16'(n), 16'(DLY));
    chk(16'(pse), 16'h0001);
    chk(16'(sse), 16'h0000);
    wt(2, 1'b1, 200, n);
    chk(16'(n >= 20), 16'h0001);
    $display("t_start done");
  endtask
  task automatic t_bins();
    logic [3:0]  b;
    logic [15:0] mask;
    int          len, hi, hi2;
    mask = 16'h0000;
    for (int i = 0; i < 16; i++) begin
      cyc(b, len, hi, hi2);
      chk(16'(len), 16'(per(b)));
      chk(16'(hi), 16'(per(b) / 2));
      chk(16'(hi2), 16'(per(b) / 2));
      mask |= 16'h0001 << b;
    end
    chk(mask, 16'hFFFF);
    $display("t_bins done");
  endtask
  task automatic t_full();
    int lo = 0;
    @(posedge clk) dp <= 8'hFF;
    repeat (1000) begin
      @(posedge clk);
      #1;
      lo += int'(!bsw);
    end
    chk(16'(lo > 0), 16'h0001);
    chk(16'(lo < 100), 16'h0001);
    @(posedge clk) dp <= 8'h80;
    #1;
    $display("t_full done");
  endtask
  task automatic t_fold();
    logic [3:0] b;
    int         n, len, hi, hi2;
    @(posedge clk) {hv20, hv18} <= 2'h2;
    #1;
    wt(5, 1'b1, 10, n);
    cyc(b, len, hi, hi2);
    chk(16'(len), 16'(per(b)));
    @(posedge clk) hv20 <= 1'b0;
    repeat (20) @(posedge clk);
    #1;
    chk(16'(fold), 16'h0001);
    @(posedge clk) hv18 <= 1'b1;
    #1;
    wt(5, 1'b0, 10, n);
    $display("t_fold done");
  endtask
  task automatic t_sync();
    logic [3:0] b;
    int         n, len, hi, hi2;
    @(posedge clk) sync_on <= 1'b1;
    #1;
    wt(3, 1'b1, 1000, n);
    repeat (2) cyc(b, len, hi, hi2);
    chk(16'(len), 16'h005A);
    chk(16'(b), 16'h0000);
    @(posedge clk) sync_on <= 1'b0;
    #1;
    wt(3, 1'b0, 500, n);
    repeat (2) cyc(b, len, hi, hi2);
    chk(16'(len), 16'(per(b)));
    $display("t_sync done");
  endtask
  task automatic t_faults();
    int n;
    @(posedge clk) {ov40, ov34} <= 2'h2;
    #1;
    wt(4, 1'b1, 10, n);
    @(posedge clk) ov40 <= 1'b0;
    repeat (20) @(posedge clk);
    #1;
    chk(16'({hss, bsw, ssw}), 16'h0004);
    @(posedge clk) ov34 <= 1'b1;
    #1;
    wt(4, 1'b0, 10, n);
    wt(1, 1'b1, 20, n);
    @(posedge clk) uv <= 1'b1;
    #1;
    wt(6, 1'b1, 10, n);
    repeat (4) @(posedge clk);
    #1;
    chk(16'({pse, sse, bsw}), 16'h0000);
    @(posedge clk) uv <= 1'b0;
    #1;
    wt(1, 1'b1, 20, n);
    @(posedge clk) en <= 1'b0;
    #1;
    wt(8, 1'b0, 10, n);
    repeat (2) @(posedge clk);
    #1;
    chk(16'({pse, sse, bsw, ssw}), 16'h0000);
    $display("t_faults done");
  endtask
  initial begin
    repeat (5) @(posedge clk);
    #1;
    chk(16'({ssr, irs, dis, fb}), 16'h0040);
    @(posedge clk) resetn <= 1'b1;
    #1;
    t_start();
    t_bins();
    t_full();
    t_fold();
    t_sync();
    t_faults();
    wrap_up();
  end
endmodule
`default_nettype wire
